// ===== ccs_calib_regs.sv
// Calibration coefficient, clock measurement and filter status registers
// of a four channel converter, reached over APB, with a read-clear
// interrupt status, its mask and one level interrupt.
// Assumes APB master on pclk; filter flags and samples come from logic on
// the same clock, so none of them is synchronised here.
//
// Design decision made here: the APB interface to the registers.
module ccs_calib_regs #(
   parameter int ADDR_W = 12,
   parameter int MEAS_DIV = ccs_pkg::MEAS_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Filter status from the channel filters
   input wire logic [ccs_pkg::NCH-1:0] filter_range_error,
   input wire logic [ccs_pkg::NCH-1:0] filter_done,
   // Sample path
   input wire logic sample_valid,
   input wire logic [ccs_pkg::NCH*ccs_pkg::DATA_W-1:0] sample_data,
   output logic [ccs_pkg::NCH-1:0] corr_valid,
   output logic [ccs_pkg::NCH*ccs_pkg::DATA_W-1:0] corr_data
);
   // ==========================================================
   // Positions inside the calibration byte array
   localparam int P_C1OH =
      ccs_pkg::IDX_CH1_OFFSET_HIGH - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2GL =
      ccs_pkg::IDX_CH2_GAIN_LOW - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2GM =
      ccs_pkg::IDX_CH2_GAIN_MIDDLE - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2GH =
      ccs_pkg::IDX_CH2_GAIN_HIGH - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2OL =
      ccs_pkg::IDX_CH2_OFFSET_LOW - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2OM =
      ccs_pkg::IDX_CH2_OFFSET_MIDDLE - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C2OH =
      ccs_pkg::IDX_CH2_OFFSET_HIGH - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3GL =
      ccs_pkg::IDX_CH3_GAIN_LOW - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3GM =
      ccs_pkg::IDX_CH3_GAIN_MIDDLE - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3GH =
      ccs_pkg::IDX_CH3_GAIN_HIGH - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3OL =
      ccs_pkg::IDX_CH3_OFFSET_LOW - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3OM =
      ccs_pkg::IDX_CH3_OFFSET_MIDDLE - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   localparam int P_C3OH =
      ccs_pkg::IDX_CH3_OFFSET_HIGH - ccs_pkg::IDX_CH1_OFFSET_HIGH;

   typedef struct packed {
      logic [ccs_pkg::CAL_BYTES-1:0][7:0] cal;
      logic meas_start;
      logic [ccs_pkg::NCH-1:0] ovf;
      logic [ccs_pkg::NCH-1:0] settle;
      logic [ccs_pkg::IRQ_W-1:0] irq_stat;
      logic [ccs_pkg::IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      logic err;
   } ccs_regs_type;

   ccs_regs_type st_ff, nxt_st;

   // ==========================================================
   // Bus decode
   logic [7:0] idx;
   logic in_range;
   logic is_cal;
   logic mapped;
   logic setup;
   logic wr_done;
   logic rd_done;
   logic [7:0] cal_pos;
   logic [7:0] wr_mask;
   logic [7:0] rd_byte;
   logic [ccs_pkg::IRQ_W-1:0] irq_set;
   logic [ccs_pkg::IRQ_W-1:0] irq_clr;

   assign idx = paddr[9:2];
   assign in_range = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
   assign is_cal = (idx >= ccs_pkg::IDX_CH1_OFFSET_HIGH) &&
                   (idx <= ccs_pkg::IDX_CH3_OFFSET_HIGH);
   assign mapped = in_range && (is_cal ||
                   (idx >= ccs_pkg::IDX_CLOCK_MEASURE_COUNTER &&
                    idx <= ccs_pkg::IDX_FILTER_SETTLE_FLAGS) ||
                   (idx >= ccs_pkg::IDX_MEASURE_CONTROL &&
                    idx <= ccs_pkg::IDX_IRQ_MASK));
   assign cal_pos = idx - ccs_pkg::IDX_CH1_OFFSET_HIGH;
   assign setup = psel && !penable;
   // Zero wait states: access phase always completes
   assign pready = 1'b1;
   assign wr_done = psel && penable && pwrite && mapped && pstrb[0];
   assign rd_done = psel && penable && !pwrite && mapped;

   // Gain top bytes keep their reserved bits at zero
   assign wr_mask = (idx == ccs_pkg::IDX_CH2_GAIN_HIGH ||
                     idx == ccs_pkg::IDX_CH3_GAIN_HIGH) ?
                    ccs_pkg::GAIN_HIGH_MASK : ccs_pkg::FULL_MASK;

   // ==========================================================
   // Clock measurement
   ccs_meas_if meas_if ();

   assign meas_if.start = st_ff.meas_start;

   ccs_clock_meter #(.DIV(MEAS_DIV)) u_meter (
      .pclk(pclk),
      .presetn(presetn),
      .mif(meas_if)
   );

   // ==========================================================
   // Coefficient fields
   logic [ccs_pkg::GAIN_W-1:0] ch2_gain_coeff;
   logic [ccs_pkg::GAIN_W-1:0] ch3_gain_coeff;
   logic [ccs_pkg::OFFSET_W-1:0] ch1_offset_coeff;
   logic [ccs_pkg::OFFSET_W-1:0] ch2_offset_coeff;
   logic [ccs_pkg::OFFSET_W-1:0] ch3_offset_coeff;
   logic ch2_gain_correct_on;
   logic ch3_gain_correct_on;
   logic ch1_offset_correct_on;
   logic ch2_offset_correct_on;
   logic ch3_offset_correct_on;

   assign ch2_gain_coeff = {st_ff.cal[P_C2GH][3:0], st_ff.cal[P_C2GM],
                            st_ff.cal[P_C2GL]};
   assign ch3_gain_coeff = {st_ff.cal[P_C3GH][3:0], st_ff.cal[P_C3GM],
                            st_ff.cal[P_C3GL]};
   // Channel 1 low offset bytes live outside this bank
   assign ch1_offset_coeff = {st_ff.cal[P_C1OH][6:0], 16'h0000};
   assign ch2_offset_coeff = {st_ff.cal[P_C2OH][6:0], st_ff.cal[P_C2OM],
                              st_ff.cal[P_C2OL]};
   assign ch3_offset_coeff = {st_ff.cal[P_C3OH][6:0], st_ff.cal[P_C3OM],
                              st_ff.cal[P_C3OL]};
   assign ch2_gain_correct_on = st_ff.cal[P_C2GH][ccs_pkg::GAIN_ON_BIT];
   assign ch3_gain_correct_on = st_ff.cal[P_C3GH][ccs_pkg::GAIN_ON_BIT];
   assign ch1_offset_correct_on =
      st_ff.cal[P_C1OH][ccs_pkg::OFFSET_ON_BIT];
   assign ch2_offset_correct_on =
      st_ff.cal[P_C2OH][ccs_pkg::OFFSET_ON_BIT];
   assign ch3_offset_correct_on =
      st_ff.cal[P_C3OH][ccs_pkg::OFFSET_ON_BIT];

   logic [ccs_pkg::NCH-1:0][ccs_pkg::GAIN_W-1:0] gain_arr;
   logic [ccs_pkg::NCH-1:0][ccs_pkg::OFFSET_W-1:0] offset_arr;
   logic [ccs_pkg::NCH-1:0] gain_on_arr;
   logic [ccs_pkg::NCH-1:0] offset_on_arr;

   // Channels without coefficients here keep their enables clear
   assign gain_arr = {ch3_gain_coeff, ch2_gain_coeff, 40'h00000_00000};
   assign gain_on_arr = {ch3_gain_correct_on, ch2_gain_correct_on, 2'h0};
   assign offset_arr = {ch3_offset_coeff, ch2_offset_coeff,
                        ch1_offset_coeff, 23'h000000};
   assign offset_on_arr = {ch3_offset_correct_on, ch2_offset_correct_on,
                           ch1_offset_correct_on, 1'h0};

   // ==========================================================
   // Per channel correction
   ccs_corr_if corr_if [ccs_pkg::NCH] ();

   for (genvar i = 0; i < ccs_pkg::NCH; i++) begin : g_chan
      assign corr_if[i].in_valid = sample_valid;
      assign corr_if[i].in_data =
         sample_data[i*ccs_pkg::DATA_W +: ccs_pkg::DATA_W];
      assign corr_if[i].gain = gain_arr[i];
      assign corr_if[i].gain_on = gain_on_arr[i];
      assign corr_if[i].offset = offset_arr[i];
      assign corr_if[i].offset_on = offset_on_arr[i];
      assign corr_valid[i] = corr_if[i].out_valid;
      assign corr_data[i*ccs_pkg::DATA_W +: ccs_pkg::DATA_W] =
         corr_if[i].out_data;

      ccs_correct u_corr (
         .pclk(pclk),
         .presetn(presetn),
         .cif(corr_if[i])
      );
   end

   // ==========================================================
   // Read data, captured in the setup phase
   always_comb begin
      rd_byte = ccs_pkg::BYTE_RESET;
      if (is_cal) begin
         rd_byte = st_ff.cal[cal_pos[3:0]];
      end else begin
         unique case (idx)
            ccs_pkg::IDX_CLOCK_MEASURE_COUNTER: rd_byte = meas_if.count;
            ccs_pkg::IDX_FILTER_OVERFLOW_FLAGS: begin
               rd_byte = {4'h0, st_ff.ovf};
            end
            ccs_pkg::IDX_FILTER_SETTLE_FLAGS: begin
               rd_byte = {4'h0, st_ff.settle};
            end
            ccs_pkg::IDX_MEASURE_CONTROL: rd_byte = {7'h00, st_ff.meas_start};
            ccs_pkg::IDX_IRQ_STATUS: rd_byte = {3'h0, st_ff.irq_stat};
            ccs_pkg::IDX_IRQ_MASK: rd_byte = {3'h0, st_ff.irq_mask};
            default: rd_byte = ccs_pkg::BYTE_RESET;
         endcase
      end
   end

   // ==========================================================
   // Register update
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ovf = filter_range_error;
      nxt_st.settle = filter_done;
      irq_set = {meas_if.done, filter_range_error & ~st_ff.ovf};
      // Clear only what the read reported; a later event stays pending
      irq_clr = (rd_done && idx == ccs_pkg::IDX_IRQ_STATUS) ?
                st_ff.rdata[ccs_pkg::IRQ_W-1:0] : '0;
      // A new event in the clearing read's cycle survives the clear
      nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;
      if (setup) begin
         nxt_st.rdata = mapped ? {24'h000000, rd_byte} : 32'h0000_0000;
         nxt_st.err = !mapped;
      end
      if (wr_done) begin
         if (is_cal) begin
            nxt_st.cal[cal_pos[3:0]] = pwdata[7:0] & wr_mask;
         end else if (idx == ccs_pkg::IDX_MEASURE_CONTROL) begin
            nxt_st.meas_start = pwdata[ccs_pkg::MEASURE_START_BIT];
         end else if (idx == ccs_pkg::IDX_IRQ_MASK) begin
            nxt_st.irq_mask = pwdata[ccs_pkg::IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.rdata;
   assign pslverr = psel && penable && st_ff.err;
   assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_setup_rd_ovf;
      setup && !pwrite && in_range &&
         idx == ccs_pkg::IDX_FILTER_OVERFLOW_FLAGS;
   endsequence
   sequence seq_setup_rd_count;
      setup && !pwrite && in_range &&
         idx == ccs_pkg::IDX_CLOCK_MEASURE_COUNTER;
   endsequence
   sequence seq_setup_rd_settle;
      setup && !pwrite && in_range && idx == ccs_pkg::IDX_FILTER_SETTLE_FLAGS;
   endsequence
   sequence seq_access;
      psel && penable;
   endsequence

   AST_RD_OVERFLOW: assert property (
      seq_setup_rd_ovf ##1 seq_access |->
         prdata == {28'h0000000, $past(st_ff.ovf)}
   ) else $error("overflow flags read back wrong");
   AST_RD_SETTLE: assert property (
      seq_setup_rd_settle ##1 seq_access |->
         prdata[31:4] == 28'h0000000 && prdata[3:0] == $past(st_ff.settle)
   ) else $error("settled flags read back wrong");
   AST_SETTLE_TRACK: assert property (
      filter_done[2] |=> st_ff.settle[2]
   ) else $error("settled flag missed its channel");
   AST_GAIN_RSVD_ZERO: assert property (
      st_ff.cal[P_C2GH][7:5] == 3'h0 && st_ff.cal[P_C3GH][7:5] == 3'h0
   ) else $error("reserved gain bits became nonzero");
   AST_RO_WRITE_IGNORED: assert property (
      (psel && penable && pwrite && !is_cal) |=> $stable(st_ff.cal)
   ) else $error("write outside coefficients changed a coefficient");
   AST_GAIN_LOW_WRITE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH2_GAIN_LOW) |=>
         ch2_gain_coeff[7:0] == $past(pwdata[7:0])
   ) else $error("gain low byte not placed at bits 7..0");
   AST_OFFSET_ENABLE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH3_OFFSET_HIGH) |=>
         ch3_offset_correct_on == $past(pwdata[ccs_pkg::OFFSET_ON_BIT]) &&
         ch3_offset_coeff[22:16] == $past(pwdata[6:0])
   ) else $error("offset top byte split wrong");
   AST_GAIN_ENABLE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH2_GAIN_HIGH) |=>
         ch2_gain_correct_on == $past(pwdata[ccs_pkg::GAIN_ON_BIT]) &&
         ch2_gain_coeff[19:16] == $past(pwdata[3:0])
   ) else $error("gain top byte split wrong");
   AST_IRQ_SET_WINS: assert property (
      (filter_range_error[0] && !st_ff.ovf[0]) |=> st_ff.irq_stat[0]
   ) else $error("range error event lost");
   AST_RD_COUNTER: assert property (
      seq_setup_rd_count ##1 seq_access |->
         prdata == {24'h000000, $past(meas_if.count)}
   ) else $error("counter read back wrong");
   AST_UNMAPPED_ERROR: assert property (
      (setup && !mapped) ##1 seq_access |->
         pslverr && prdata == 32'h0000_0000
   ) else $error("unmapped access not refused");
   AST_OFFSET_LOW_WRITE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH2_OFFSET_LOW) |=>
         ch2_offset_coeff[7:0] == $past(pwdata[7:0])
   ) else $error("offset low byte not placed at bits 7..0");
   AST_GAIN_MID_WRITE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH3_GAIN_MIDDLE) |=>
         ch3_gain_coeff[15:8] == $past(pwdata[7:0])
   ) else $error("gain middle byte not placed at bits 15..8");
   AST_CH1_OFFSET_ENABLE: assert property (
      (wr_done && idx == ccs_pkg::IDX_CH1_OFFSET_HIGH) |=>
         ch1_offset_correct_on == $past(pwdata[ccs_pkg::OFFSET_ON_BIT]) &&
         ch1_offset_coeff[22:16] == $past(pwdata[6:0])
   ) else $error("channel 1 offset top byte split wrong");
   AST_OVERFLOW_TRACK: assert property (
      filter_range_error[1] |=> st_ff.ovf[1]
   ) else $error("overflow flag missed its channel");
   AST_IRQ_UNREPORTED_KEPT: assert property (
      (rd_done && idx == ccs_pkg::IDX_IRQ_STATUS &&
       st_ff.irq_stat[0] && !st_ff.rdata[0]) |=> st_ff.irq_stat[0]
   ) else $error("read cleared an event it did not report");
endmodule

// ===== ccs_clock_meter.sv
// Master clock measurement counter: one step per DIV clock cycles.
// Assumes start is a level from the register bank on the same clock.
module ccs_clock_meter #(
   parameter int DIV = ccs_pkg::MEAS_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control and result
   ccs_meas_if.meas mif
);
   localparam int PW = $clog2(DIV);
   localparam logic [PW-1:0] DIV_M1 = PW'(DIV - 1);

   typedef struct packed {
      logic start_d;
      logic [PW-1:0] pre;
      logic [7:0] count;
      logic done;
   } ccs_meter_type;

   ccs_meter_type st_ff, nxt_st;
   logic restart;

   assign restart = mif.start && !st_ff.start_d;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.start_d = mif.start;
      nxt_st.done = 1'b0;
      if (restart) begin
         nxt_st.pre = '0;
         nxt_st.count = '0;
      end else if (mif.start && st_ff.count != ccs_pkg::MEAS_MAX) begin
         if (st_ff.pre == DIV_M1) begin
            nxt_st.pre = '0;
            nxt_st.count = st_ff.count + 8'h01;
            nxt_st.done = (st_ff.count == ccs_pkg::MEAS_MAX - 8'h01);
         end else begin
            nxt_st.pre = st_ff.pre + PW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mif.count = st_ff.count;
   assign mif.done = st_ff.done;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_MEAS_STEP: assert property (
      ($changed(st_ff.count) && !$past(restart)) |-> $past(st_ff.pre) == DIV_M1
   ) else $error("counter stepped before prescaler wrapped");
   AST_MEAS_HOLD_MAX: assert property (
      (st_ff.count == ccs_pkg::MEAS_MAX && !restart) |=>
         st_ff.count == ccs_pkg::MEAS_MAX
   ) else $error("counter left its saturated value");
endmodule

// ===== ccs_correct.sv
// Gain and offset correction of one channel, one cycle of latency.
// Assumes the gain coefficient is unsigned with unity at 2**GAIN_FRAC.
module ccs_correct (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample in, coefficients and corrected sample out
   ccs_corr_if.dp cif
);
   localparam int PW = ccs_pkg::DATA_W + ccs_pkg::GAIN_W + 2;
   localparam logic signed [PW-1:0] POS_MAX =
      PW'(2 ** (ccs_pkg::DATA_W - 1) - 1);
   localparam logic signed [PW-1:0] NEG_MIN =
      -PW'(2 ** (ccs_pkg::DATA_W - 1));

   typedef struct packed {
      logic valid;
      logic [ccs_pkg::DATA_W-1:0] data;
   } ccs_corr_type;

   ccs_corr_type st_ff, nxt_st;
   logic signed [ccs_pkg::DATA_W:0] sum;
   logic signed [PW-1:0] prod;

   always_comb begin
      nxt_st.valid = cif.in_valid;
      sum = (ccs_pkg::DATA_W+1)'(cif.in_data);
      if (cif.offset_on) begin
         sum = sum + (ccs_pkg::DATA_W+1)'($signed(cif.offset));
      end
      prod = PW'(sum);
      if (cif.gain_on) begin
         prod = (PW'(sum) * $signed(PW'({1'b0, cif.gain}))) >>>
                ccs_pkg::GAIN_FRAC;
      end
      // Clamp instead of wrapping so a bad coefficient cannot flip sign
      if (prod > POS_MAX) begin
         nxt_st.data = POS_MAX[ccs_pkg::DATA_W-1:0];
      end else if (prod < NEG_MIN) begin
         nxt_st.data = NEG_MIN[ccs_pkg::DATA_W-1:0];
      end else begin
         nxt_st.data = prod[ccs_pkg::DATA_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cif.out_valid = st_ff.valid;
   assign cif.out_data = st_ff.data;

   AST_PASS_THROUGH: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cif.in_valid && !cif.gain_on && !cif.offset_on) |=>
         (cif.out_valid && cif.out_data == $past(cif.in_data))
   ) else $error("disabled correction altered the sample");
endmodule

// ===== ccs_filter_model.sv
// Far-side model of the channel filters: overflow and settle levels.
// Assumes the bench sets wanted levels; outputs move just after an edge.
module ccs_filter_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Wanted and driven levels
   input wire logic [3:0] want_err,
   input wire logic [3:0] want_done,
   output logic [3:0] range_error,
   output logic [3:0] done
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_error <= 4'h0;
         done <= 4'h0;
      end else begin
         range_error <= want_err;
         done <= want_done;
      end
   end
endmodule

// ===== ccs_if.sv
// Carriers between the register bank and its two helper modules.
// Assumes one clock; all signals are synchronous to pclk.
interface ccs_meas_if;
   logic start;
   logic [7:0] count;
   logic done;
   modport ctl (output start, input count, input done);
   modport meas (input start, output count, output done);
endinterface

interface ccs_corr_if;
   logic in_valid;
   logic signed [ccs_pkg::DATA_W-1:0] in_data;
   logic [ccs_pkg::GAIN_W-1:0] gain;
   logic gain_on;
   logic [ccs_pkg::OFFSET_W-1:0] offset;
   logic offset_on;
   logic out_valid;
   logic signed [ccs_pkg::DATA_W-1:0] out_data;
   modport src (output in_valid, in_data, gain, gain_on, offset, offset_on,
                input out_valid, out_data);
   modport dp (input in_valid, in_data, gain, gain_on, offset, offset_on,
               output out_valid, out_data);
endinterface

// ===== ccs_pkg.sv
// Shared constants of the channel calibration and status register bank.
// Assumes a 32-bit APB slave, one register per aligned word.
package ccs_pkg;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CH1_OFFSET_HIGH = 8'h32;
   localparam logic [7:0] IDX_CH2_GAIN_LOW = 8'h33;
   localparam logic [7:0] IDX_CH2_GAIN_MIDDLE = 8'h34;
   localparam logic [7:0] IDX_CH2_GAIN_HIGH = 8'h35;
   localparam logic [7:0] IDX_CH2_OFFSET_LOW = 8'h36;
   localparam logic [7:0] IDX_CH2_OFFSET_MIDDLE = 8'h37;
   localparam logic [7:0] IDX_CH2_OFFSET_HIGH = 8'h38;
   localparam logic [7:0] IDX_CH3_GAIN_LOW = 8'h39;
   localparam logic [7:0] IDX_CH3_GAIN_MIDDLE = 8'h3A;
   localparam logic [7:0] IDX_CH3_GAIN_HIGH = 8'h3B;
   localparam logic [7:0] IDX_CH3_OFFSET_LOW = 8'h3C;
   localparam logic [7:0] IDX_CH3_OFFSET_MIDDLE = 8'h3D;
   localparam logic [7:0] IDX_CH3_OFFSET_HIGH = 8'h3E;
   localparam logic [7:0] IDX_CLOCK_MEASURE_COUNTER = 8'h3F;
   localparam logic [7:0] IDX_FILTER_OVERFLOW_FLAGS = 8'h40;
   localparam logic [7:0] IDX_FILTER_SETTLE_FLAGS = 8'h41;
   localparam logic [7:0] IDX_MEASURE_CONTROL = 8'h50;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h51;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h52;

   // ==========================================================
   // Calibration byte array layout
   localparam int CAL_BYTES = 13;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] GAIN_HIGH_MASK = 8'h1F;
   localparam logic [7:0] FULL_MASK = 8'hFF;
   localparam int GAIN_ON_BIT = 4;
   localparam int OFFSET_ON_BIT = 7;
   localparam int GAIN_W = 20;
   localparam int OFFSET_W = 23;
   localparam int GAIN_FRAC = 19;
   localparam int DATA_W = 24;
   localparam int NCH = 4;
   localparam int MEASURE_START_BIT = 0;

   // ==========================================================
   // Clock measurement and interrupt layout
   localparam int MEAS_CYCLES = 12000;
   localparam logic [7:0] MEAS_MAX = 8'hFF;
   localparam int IRQ_W = 5;
   localparam int IRQ_MEAS_BIT = 4;

endpackage

// ===== testbench.sv
// Self-checking bench of the calibration and status register bank.
// Assumes zero wait APB, one cycle sample latency, MEAS_DIV set to 10.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic sample_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb, fe, fd, want_err, want_done, corr_valid;
   logic [95:0] sample_data, corr_data;
   logic [7:0] cb [13];
   int err_total, cmp_count, cyc;

   ccs_calib_regs #(.ADDR_W(12), .MEAS_DIV(10)) ccs_calib_regs_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .filter_range_error(fe), .filter_done(fd),
      .sample_valid(sample_valid), .sample_data(sample_data),
      .corr_valid(corr_valid), .corr_data(corr_data));
   ccs_filter_model ccs_filter_model_i (.pclk(pclk), .presetn(presetn),
      .want_err(want_err), .want_done(want_done), .range_error(fe),
      .done(fd));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ==========================================================
   // Shared tasks
   task automatic finish_test();
      $display("errors %0d of %0d checks", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One idle edge first, so strobes never change twice in a step
   task automatic apb(input logic [7:0] idx, input logic wr,
                      input logic [31:0] wd, input logic [3:0] st);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(idx, 1'b1, {24'h0, d}, 4'hF);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] x);
      apb(idx, 1'b0, 32'h0, 4'hF);
      chk(r, {24'h0, x});
   endtask

   function automatic logic [23:0] ex(input logic [23:0] x,
      input logic [22:0] o, input logic oo, input logic [19:0] g,
      input logic go);
      longint v;
      v = longint'($signed(x));
      if (oo) v = v + longint'($signed(o));
      if (go) v = (v * longint'(g)) >>> 19;
      if (v > 8388607) v = 8388607;
      if (v < -8388608) v = -8388608;
      return v[23:0];
   endfunction

   task automatic samp();
      logic [95:0] d;
      d = {$urandom, $urandom, $urandom};
      sample_valid <= 1'b1;
      sample_data <= d;
      @(posedge pclk);
      sample_valid <= 1'b0;
      #1;
      chk({28'h0, corr_valid}, 32'hF);
      chk({8'h0, corr_data[23:0]}, {8'h0, d[23:0]});
      chk({8'h0, corr_data[47:24]}, {8'h0, ex(d[47:24],
         {cb[0][6:0], 16'h0}, cb[0][7], 20'h0, 1'b0)});
      chk({8'h0, corr_data[71:48]}, {8'h0, ex(d[71:48],
         {cb[6][6:0], cb[5], cb[4]}, cb[6][7],
         {cb[3][3:0], cb[2], cb[1]}, cb[3][4])});
      chk({8'h0, corr_data[95:72]}, {8'h0, ex(d[95:72],
         {cb[12][6:0], cb[11], cb[10]}, cb[12][7],
         {cb[9][3:0], cb[8], cb[7]}, cb[9][4])});
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         $display("CHECK FAILED at %0t: timeout", $time);
         finish_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, sample_valid} = 5'h00;
      {paddr, pwdata, pstrb, want_err, want_done} = 56'h0;
      sample_data = 96'h0;
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      r = $urandom(40);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 8'h32; i <= 8'h52; i++)
         if (i < 8'h42 || i > 8'h4F) rdc(i[7:0], 8'h00);
      apb(8'h60, 1'b0, 32'h0, 4'hF);
      chk({r[31:1], e}, 32'h1);
      chk({31'h0, pready}, 32'h1);
      // Pass one clears every enable, pass two sets every writable bit
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 13; j++) begin
            cb[j] = (k == 1) ? 8'hFF : 8'($urandom);
            if (k == 0) cb[j] &= 8'h6F;
            wr(8'h32 + j[7:0], cb[j]);
            if (j == 3 || j == 9) cb[j] &= 8'h1F;
         end
         for (int j = 0; j < 13; j++) rdc(8'h32 + j[7:0], cb[j]);
         repeat (4) samp();
      end
      apb(8'h33, 1'b1, 32'hA5, 4'hE);
      rdc(8'h33, cb[1]);
      for (int i = 8'h3F; i <= 8'h41; i++) begin
         wr(i[7:0], 8'hFF);
         rdc(i[7:0], 8'h00);
      end
      wr(8'h52, 8'h1F);
      want_err <= 4'($urandom) | 4'h1;
      want_done <= 4'($urandom);
      repeat (3) @(posedge pclk);
      rdc(8'h40, {4'h0, want_err});
      rdc(8'h41, {4'h0, want_done});
      chk({31'h0, irq}, 32'h1);
      rdc(8'h51, {4'h0, want_err});
      #1 chk({31'h0, irq}, 32'h0);
      wr(8'h52, 8'h10);
      want_err <= 4'h0;
      repeat (3) @(posedge pclk);
      want_err <= 4'hF;
      repeat (3) @(posedge pclk);
      #1 chk({31'h0, irq}, 32'h0);
      rdc(8'h51, 8'h0F);
      wr(8'h50, 8'h01);
      repeat (55) @(posedge pclk);
      rdc(8'h3F, 8'h05);
      repeat (2600) @(posedge pclk);
      rdc(8'h3F, 8'hFF);
      #1 chk({31'h0, irq}, 32'h1);
      rdc(8'h51, 8'h10);
      finish_test();
   end
endmodule
